//--- rtl/sdram_cmd_pkg.sv
// constants and types shared by the command decoder files
`default_nettype none
package sdram_cmd_pkg;

  // decoded command codes
  typedef enum logic [3:0] {
    CMD_NO_OPERATION = 4'h0,
    CMD_MODE_REGISTER_SET = 4'h1,
    CMD_REFRESH = 4'h2,
    CMD_SELF_REFRESH_ENTRY = 4'h3,
    CMD_SELF_REFRESH_EXIT = 4'h4,
    CMD_BANK_PRECHARGE = 4'h5,
    CMD_ALL_BANK_PRECHARGE = 4'h6,
    CMD_BANK_ACTIVATE = 4'h7,
    CMD_WRITE = 4'h8,
    CMD_READ = 4'h9,
    CMD_POWER_DOWN_ENTRY = 4'ha,
    CMD_POWER_DOWN_EXIT = 4'hb,
    CMD_IMPEDANCE_CAL_LONG = 4'hc,
    CMD_IMPEDANCE_CAL_SHORT = 4'hd,
    CMD_ILLEGAL = 4'he
  } cmd_t;

  // power states
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_POWER_DOWN = 2'h1,
    PWR_SELF_REFRESH = 2'h2
  } pwr_t;

  // burst setting held from mode register 0, opcode bits 1:0
  localparam logic [1:0] BURST_FIXED_BL8 = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED_BC4 = 2'h2;
  localparam logic [1:0] BURST_MODE_RESET = 2'h0;
  localparam int BURST_FIELD_LSB = 0;
  localparam logic [2:0] MODE_REG0_SEL = 3'h0;

  // address bit positions
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int BURST_CHOP_BIT = 12;

  // burst length in link clock cycles (two beats per cycle)
  localparam logic [2:0] BURST_CYC_BL8 = 3'h4;
  localparam logic [2:0] BURST_CYC_BC4 = 3'h2;

endpackage : sdram_cmd_pkg
`default_nettype wire

//--- rtl/sync_2ff.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : sync_2ff
`default_nettype wire

//--- rtl/sdram_command_decoder.sv
// command decoder of the sdram device
// Notes on behaviour
// [RULE1] commands come only from strobes and clock enable at link clock rise, except self-refresh exit, taken on clock enable high alone
// [RULE2] all strobes low is mode register set; write strobe high is refresh
// [RULE3] bank lines pick the bank; row strobe alone low is bank activate
// [RULE4] column and write strobes low is a write with mode burst setting
// [RULE5] column strobe low with write strobe high is a read
// [RULE6] on the fly, chop bit low gives four beats, high gives eight
// [RULE7] auto-close bit: auto precharge, all banks, or long calibration
// [RULE8] bursts never cut short; burst fixed or on the fly per mode
// [RULE9] chip select low, strobes high is no-operation; bursts go on
// [RULE10] chip select high is deselect, handled as no-operation
// [RULE11] controller sends no-operation while the device waits
// [RULE12] clock enable fall or rise with idle enters or leaves power-down
// [RULE13] refresh pattern with clock enable fall enters self-refresh
// [RULE14] controller waits 512 cycles after self-refresh exit to write
// [RULE15] termination input never alters commands; off in self-refresh
// [RULE16] controller keeps reset high in normal operation
// [RULE17] controller drives defined levels on valid fields
// [RULE18] controller enters self-refresh only with all banks idle
// [RULE19] unlisted strobe and clock enable patterns are illegal
// [RULE20] row and column strobes high, write low is impedance calibration
`timescale 1ns/1ns
`default_nettype none
module sdram_command_decoder #(
  parameter int BANK_W = 3,
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link from the controller
  input wire logic link_clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic termination_control,
  // decoded command
  output sdram_cmd_pkg::cmd_t cmd_r,
  output logic cmd_strobe_r,
  output logic [BANK_W-1:0] bank_r,
  output logic [ADDR_W-1:0] addr_r,
  output logic auto_precharge_r,
  output logic burst_chop_r,
  // device state
  output sdram_cmd_pkg::pwr_t pwr_state_r,
  output logic burst_active_r,
  output logic [1:0] burst_mode_r,
  output logic termination_enable_r
);

  localparam int SYNC_W = BANK_W + ADDR_W + 7;

  initial
  begin
    if (ADDR_W < 13 || BANK_W < 1)
      $error("address must reach the chop bit, bank at least one bit");
  end

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] sync_q;
  logic clk_s;
  logic clk_d_r;
  logic cke_s;
  logic cs_s;
  logic ras_s;
  logic cas_s;
  logic we_s;
  logic term_s;
  logic [BANK_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic link_edge;

  sync_2ff #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({link_clk, cke, cs_n, ras_n, cas_n, we_n, termination_control,
      ba, addr}),
    .dout(sync_q)
  );

  assign {clk_s, cke_s, cs_s, ras_s, cas_s, we_s, term_s, ba_s, addr_s} =
    sync_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      clk_d_r <= 1'b0;
    else
      clk_d_r <= clk_s;
  end

  assign link_edge = clk_s & ~clk_d_r; // RULE1

  // ==========================================================
  // command decode
  function automatic sdram_cmd_pkg::cmd_t decode(
    input logic prev,
    input logic cur,
    input logic cs,
    input logic [2:0] strobes,
    input logic ac,
    input sdram_cmd_pkg::pwr_t st
  );
    logic idle;
    idle = cs | (strobes == 3'h7); // RULE9 RULE10
    decode = sdram_cmd_pkg::CMD_ILLEGAL; // RULE19
    if (prev && cur)
    begin
      if (cs)
        decode = sdram_cmd_pkg::CMD_NO_OPERATION; // RULE10
      else
      begin
        case (strobes)
          3'h0: decode = sdram_cmd_pkg::CMD_MODE_REGISTER_SET; // RULE2
          3'h1: decode = sdram_cmd_pkg::CMD_REFRESH; // RULE2
          3'h2: decode = ac ? sdram_cmd_pkg::CMD_ALL_BANK_PRECHARGE
                            : sdram_cmd_pkg::CMD_BANK_PRECHARGE; // RULE7
          3'h3: decode = sdram_cmd_pkg::CMD_BANK_ACTIVATE; // RULE3
          3'h4: decode = sdram_cmd_pkg::CMD_WRITE; // RULE4
          3'h5: decode = sdram_cmd_pkg::CMD_READ; // RULE5
          3'h6: decode = ac ? sdram_cmd_pkg::CMD_IMPEDANCE_CAL_LONG
                            : sdram_cmd_pkg::CMD_IMPEDANCE_CAL_SHORT; // RULE20
          default: decode = sdram_cmd_pkg::CMD_NO_OPERATION; // RULE9
        endcase
      end
    end
    else if (prev && !cur)
    begin
      if (idle)
        decode = sdram_cmd_pkg::CMD_POWER_DOWN_ENTRY; // RULE12
      else if (!cs && strobes == 3'h1)
        decode = sdram_cmd_pkg::CMD_SELF_REFRESH_ENTRY; // RULE13
    end
    else if (!prev && cur)
    begin
      if (idle && st == sdram_cmd_pkg::PWR_POWER_DOWN)
        decode = sdram_cmd_pkg::CMD_POWER_DOWN_EXIT; // RULE12
    end
    else
      decode = sdram_cmd_pkg::CMD_NO_OPERATION;
  endfunction : decode

  logic cke_prev_r;
  sdram_cmd_pkg::cmd_t cmd_nxt;
  logic sr_exit;
  logic rw_cmd;
  logic chop_nxt;
  logic [2:0] burst_cnt_r;

  assign sr_exit = (pwr_state_r == sdram_cmd_pkg::PWR_SELF_REFRESH)
    && cke_s; // RULE13
  assign cmd_nxt = decode(cke_prev_r, cke_s, cs_s, {ras_s, cas_s, we_s},
    addr_s[sdram_cmd_pkg::AUTO_CLOSE_BIT], pwr_state_r);
  assign rw_cmd = (cmd_nxt == sdram_cmd_pkg::CMD_WRITE)
    || (cmd_nxt == sdram_cmd_pkg::CMD_READ);

  always_comb
  begin
    case (burst_mode_r)
      sdram_cmd_pkg::BURST_ON_THE_FLY:
        chop_nxt = ~addr_s[sdram_cmd_pkg::BURST_CHOP_BIT]; // RULE6
      sdram_cmd_pkg::BURST_FIXED_BC4: chop_nxt = 1'b1; // RULE8
      default: chop_nxt = 1'b0; // RULE8
    endcase
  end

  // ==========================================================
  // clock enable history
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cke_prev_r <= 1'b0;
    else if (sr_exit)
      cke_prev_r <= 1'b1; // RULE13
    else if (link_edge)
      cke_prev_r <= cke_s;
  end

  // ==========================================================
  // power state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pwr_state_r <= sdram_cmd_pkg::PWR_ACTIVE;
    else if (sr_exit)
      pwr_state_r <= sdram_cmd_pkg::PWR_ACTIVE; // RULE13
    else if (link_edge)
    begin
      case (cmd_nxt)
        sdram_cmd_pkg::CMD_POWER_DOWN_ENTRY:
          pwr_state_r <= sdram_cmd_pkg::PWR_POWER_DOWN; // RULE12
        sdram_cmd_pkg::CMD_POWER_DOWN_EXIT:
          pwr_state_r <= sdram_cmd_pkg::PWR_ACTIVE; // RULE12
        sdram_cmd_pkg::CMD_SELF_REFRESH_ENTRY:
          pwr_state_r <= sdram_cmd_pkg::PWR_SELF_REFRESH; // RULE13
        default: pwr_state_r <= pwr_state_r;
      endcase
    end
  end

  // ==========================================================
  // command outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r <= sdram_cmd_pkg::CMD_NO_OPERATION;
      cmd_strobe_r <= 1'b0;
      bank_r <= '0;
      addr_r <= '0;
      auto_precharge_r <= 1'b0;
      burst_chop_r <= 1'b0;
    end
    else if (sr_exit)
    begin
      cmd_r <= sdram_cmd_pkg::CMD_SELF_REFRESH_EXIT; // RULE13
      cmd_strobe_r <= 1'b1;
      auto_precharge_r <= 1'b0;
      burst_chop_r <= 1'b0;
    end
    else if (link_edge)
    begin
      cmd_strobe_r <= 1'b1;
      bank_r <= ba_s; // RULE3
      addr_r <= addr_s;
      if (rw_cmd && burst_active_r)
        cmd_r <= sdram_cmd_pkg::CMD_ILLEGAL; // RULE8
      else if (cmd_nxt == sdram_cmd_pkg::CMD_REFRESH
               && pwr_state_r != sdram_cmd_pkg::PWR_ACTIVE)
        cmd_r <= sdram_cmd_pkg::CMD_ILLEGAL; // RULE12
      else
        cmd_r <= cmd_nxt;
      auto_precharge_r <= rw_cmd
        & addr_s[sdram_cmd_pkg::AUTO_CLOSE_BIT]; // RULE7
      burst_chop_r <= rw_cmd & chop_nxt; // RULE6
    end
    else
      cmd_strobe_r <= 1'b0;
  end

  // ==========================================================
  // burst setting from mode register set
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      burst_mode_r <= sdram_cmd_pkg::BURST_MODE_RESET;
    else if (link_edge && !sr_exit
             && cmd_nxt == sdram_cmd_pkg::CMD_MODE_REGISTER_SET
             && ba_s == BANK_W'(sdram_cmd_pkg::MODE_REG0_SEL))
      burst_mode_r <= addr_s[sdram_cmd_pkg::BURST_FIELD_LSB +: 2]; // RULE2
  end

  // ==========================================================
  // burst tracking, never cut short
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burst_cnt_r <= 3'h0;
      burst_active_r <= 1'b0;
    end
    else if (link_edge && !sr_exit)
    begin
      if (rw_cmd && !burst_active_r)
      begin
        burst_cnt_r <= chop_nxt ? sdram_cmd_pkg::BURST_CYC_BC4
                                : sdram_cmd_pkg::BURST_CYC_BL8; // RULE8
        burst_active_r <= 1'b1;
      end
      else if (burst_active_r)
      begin
        burst_cnt_r <= burst_cnt_r - 3'h1; // RULE9
        burst_active_r <= (burst_cnt_r != 3'h1);
      end
    end
  end

  // ==========================================================
  // termination enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      termination_enable_r <= 1'b0;
    else
      termination_enable_r <= term_s
        & (pwr_state_r != sdram_cmd_pkg::PWR_SELF_REFRESH); // RULE15
  end

  // ==========================================================
  // assertions
  a_strobe_on_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit |=> cmd_strobe_r) // RULE1
    else $error("command not strobed after link edge");
  a_refresh_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && cke_prev_r && cke_s && !cs_s && !ras_s
    && !cas_s && we_s && pwr_state_r == sdram_cmd_pkg::PWR_ACTIVE
    |=> cmd_r == sdram_cmd_pkg::CMD_REFRESH) // RULE2
    else $error("refresh pattern not decoded");
  a_activate_bank: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit
    |=> bank_r == $past(ba_s)) // RULE3
    else $error("bank not captured");
  a_write_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && cmd_nxt == sdram_cmd_pkg::CMD_WRITE
    && !burst_active_r |=> cmd_r == sdram_cmd_pkg::CMD_WRITE
    && burst_active_r) // RULE4
    else $error("write not decoded");
  a_read_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && cke_prev_r && cke_s && !cs_s && ras_s
    && !cas_s && we_s |-> cmd_nxt == sdram_cmd_pkg::CMD_READ) // RULE5
    else $error("read not decoded");
  a_chop_fly: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && rw_cmd
    && burst_mode_r == sdram_cmd_pkg::BURST_ON_THE_FLY
    |=> burst_chop_r == !$past(addr_s[12])) // RULE6
    else $error("chop bit misread");
  a_auto_close: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && rw_cmd
    |=> auto_precharge_r == $past(addr_s[10])) // RULE7
    else $error("auto precharge misread");
  a_burst_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && burst_active_r && burst_cnt_r > 3'h1
    |=> burst_active_r) // RULE8
    else $error("burst ended early");
  a_deselect_nop: assert property (@(posedge mclk) disable iff (!rst_n)
    cke_prev_r && cke_s && cs_s
    |-> cmd_nxt == sdram_cmd_pkg::CMD_NO_OPERATION) // RULE10
    else $error("deselect not a no-operation");
  a_pd_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    link_edge && !sr_exit && cmd_nxt == sdram_cmd_pkg::CMD_POWER_DOWN_ENTRY
    |=> pwr_state_r == sdram_cmd_pkg::PWR_POWER_DOWN) // RULE12
    else $error("power-down not entered");
  a_sr_exit: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_r == sdram_cmd_pkg::PWR_SELF_REFRESH && cke_s
    |=> pwr_state_r == sdram_cmd_pkg::PWR_ACTIVE
    && cmd_r == sdram_cmd_pkg::CMD_SELF_REFRESH_EXIT) // RULE13
    else $error("self-refresh exit missed");
  a_term_off_sr: assert property (@(posedge mclk) disable iff (!rst_n)
    pwr_state_r == sdram_cmd_pkg::PWR_SELF_REFRESH
    |=> !termination_enable_r) // RULE15
    else $error("termination on in self-refresh");
  a_zq_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    cke_prev_r && cke_s && !cs_s && ras_s && cas_s && !we_s
    |-> cmd_nxt == sdram_cmd_pkg::CMD_IMPEDANCE_CAL_LONG
    || cmd_nxt == sdram_cmd_pkg::CMD_IMPEDANCE_CAL_SHORT) // RULE20
    else $error("calibration not decoded");
  a_illegal_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
    cke_prev_r && !cke_s && !cs_s && {ras_s, cas_s, we_s} != 3'h1
    && {ras_s, cas_s, we_s} != 3'h7
    |-> cmd_nxt == sdram_cmd_pkg::CMD_ILLEGAL) // RULE19
    else $error("reserved pattern accepted");

endmodule : sdram_command_decoder
`default_nettype wire

//--- bench/ctrl_model.sv
// controller model that drives the command link of the decoder
`timescale 1ns/1ns
`default_nettype none
module ctrl_model #(
  parameter int BANK_W = 3,
  parameter int ADDR_W = 16
) (
  // clock
  input wire logic mclk,
  // command link
  output var logic link_clk,
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic [BANK_W-1:0] ba,
  output var logic [ADDR_W-1:0] addr
);
  int since_exit;
  bit in_sr;

  // ==========================================================
  // link clock, free running, 160 ns period, each rise 2 ns after an mclk rise
  initial
  begin
    link_clk = 1'b0;
    cke = 1'b0;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = '0;
    addr = '0;
    since_exit = 512;
    in_sr = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // ==========================================================
  // link edges counted since self-refresh exit
  always @(posedge link_clk)
    if (since_exit < 512)
      since_exit <= since_exit + 1;

  // ==========================================================
  // one command: s is cs, row, column, write strobe
  task automatic send(input logic c, input logic [3:0] s,
    input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    if (s == 4'h4)
      while (since_exit < 512) @(posedge link_clk);
    @(negedge link_clk);
    @(posedge mclk);
    if (c && !cke && in_sr)
    begin
      in_sr = 1'b0;
      since_exit = 0;
    end
    if (!c && cke && s == 4'h1)
      in_sr = 1'b1;
    cke <= c;
    cs_n <= s[3];
    if (s[3])
    begin
      // released lines toggle so no stale level is seen
      {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
      ba <= ~ba;
      addr <= ~addr;
    end
    else
    begin
      {ras_n, cas_n, we_n} <= s[2:0];
      ba <= b;
      addr <= a;
    end
  endtask : send
endmodule : ctrl_model
`default_nettype wire

//--- bench/tb.sv
// self-checking testbench of the command decoder
`timescale 1ns/1ns
`default_nettype none
`define check(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("unexpected %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb;
  logic mclk, rst_n, link_clk, cke, cs_n, ras_n, cas_n, we_n, term;
  logic [2:0] ba, bank_r;
  logic [15:0] addr, addr_r;
  sdram_cmd_pkg::cmd_t cmd_r;
  sdram_cmd_pkg::pwr_t pwr_state_r;
  logic strobe, ap, chop, busy, term_en;
  logic [1:0] mode;
  int errors = 0;
  int comparisons = 0;

  // ==========================================================
  // clock, design and partner
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  sdram_command_decoder #(.BANK_W(3), .ADDR_W(16)) sdram_command_decoder_inst (
    .mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .termination_control(term), .cmd_r(cmd_r),
    .cmd_strobe_r(strobe), .bank_r(bank_r), .addr_r(addr_r),
    .auto_precharge_r(ap), .burst_chop_r(chop), .pwr_state_r(pwr_state_r),
    .burst_active_r(busy), .burst_mode_r(mode), .termination_enable_r(term_en)
  );
  ctrl_model #(.BANK_W(3), .ADDR_W(16)) ctrl_model_inst (
    .mclk(mclk), .link_clk(link_clk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr)
  );

  // ==========================================================
  // shared tasks
  task automatic issue(input logic c, input logic [3:0] s,
    input logic [2:0] b, input logic [15:0] a,
    input sdram_cmd_pkg::cmd_t exp);
    bit seen;
    seen = 1'b0;
    ctrl_model_inst.send(c, s, b, a);
    for (int i = 0; i < 30 && !seen; i++)
    begin
      @(posedge mclk);
      seen = (strobe === 1'b1);
    end
    `check("strobe", 1'b1, seen)
    `check("cmd", exp, cmd_r)
  endtask : issue

  task automatic idle(input int n);
    repeat (n) issue(1'b1, 4'h7, 3'h0, 16'h0, sdram_cmd_pkg::CMD_NO_OPERATION);
  endtask : idle

  task automatic finish_test;
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // ==========================================================
  // scenarios
  task automatic t_table;
    logic [3:0] s[8] = '{4'h1, 4'h3, 4'h2, 4'h2, 4'h6, 4'h6, 4'h7, 4'h8};
    logic [2:0] b[8] = '{3'h0, 3'h5, 3'h3, 3'h0, 3'h6, 3'h1, 3'h2, 3'h0};
    logic [15:0] a[8] = '{16'h0, 16'h1234, 16'h0, 16'h0400, 16'h0400,
      16'h0, 16'h0, 16'h0};
    sdram_cmd_pkg::cmd_t e[8] = '{sdram_cmd_pkg::CMD_REFRESH,
      sdram_cmd_pkg::CMD_BANK_ACTIVATE, sdram_cmd_pkg::CMD_BANK_PRECHARGE,
      sdram_cmd_pkg::CMD_ALL_BANK_PRECHARGE,
      sdram_cmd_pkg::CMD_IMPEDANCE_CAL_LONG,
      sdram_cmd_pkg::CMD_IMPEDANCE_CAL_SHORT,
      sdram_cmd_pkg::CMD_NO_OPERATION, sdram_cmd_pkg::CMD_NO_OPERATION};
    for (int i = 0; i < 8; i++)
    begin
      issue(1'b1, s[i], b[i], a[i], e[i]);
      if (i < 4)
      begin
        `check("bank", b[i], bank_r)
        `check("addr", a[i], addr_r)
      end
    end
  endtask : t_table

  task automatic t_burst;
    issue(1'b1, 4'h0, 3'h0, 16'h0001, sdram_cmd_pkg::CMD_MODE_REGISTER_SET);
    `check("mode", sdram_cmd_pkg::BURST_ON_THE_FLY, mode)
    issue(1'b1, 4'h4, 3'h2, 16'h1408, sdram_cmd_pkg::CMD_WRITE);
    `check("chop", 1'b0, chop)
    `check("autopre", 1'b1, ap)
    `check("bank", 3'h2, bank_r)
    issue(1'b1, 4'h5, 3'h1, 16'h0010, sdram_cmd_pkg::CMD_ILLEGAL);
    `check("busy", 1'b1, busy)
    issue(1'b1, 4'h7, 3'h0, 16'h0, sdram_cmd_pkg::CMD_NO_OPERATION);
    `check("busy", 1'b1, busy)
    idle(4);
    `check("busy", 1'b0, busy)
    issue(1'b1, 4'h5, 3'h1, 16'h0020, sdram_cmd_pkg::CMD_READ);
    `check("chop", 1'b1, chop)
    `check("autopre", 1'b0, ap)
    `check("addr", 16'h0020, addr_r)
    idle(4);
    issue(1'b1, 4'h0, 3'h0, 16'h0002, sdram_cmd_pkg::CMD_MODE_REGISTER_SET);
    `check("mode", sdram_cmd_pkg::BURST_FIXED_BC4, mode)
    issue(1'b1, 4'h4, 3'h4, 16'h1000, sdram_cmd_pkg::CMD_WRITE);
    `check("chop", 1'b1, chop)
    idle(4);
  endtask : t_burst

  task automatic t_power;
    issue(1'b0, 4'h7, 3'h0, 16'h0, sdram_cmd_pkg::CMD_POWER_DOWN_ENTRY);
    `check("pwr", sdram_cmd_pkg::PWR_POWER_DOWN, pwr_state_r)
    issue(1'b1, 4'h8, 3'h0, 16'h0, sdram_cmd_pkg::CMD_POWER_DOWN_EXIT);
    `check("pwr", sdram_cmd_pkg::PWR_ACTIVE, pwr_state_r)
    idle(2);
  endtask : t_power

  task automatic t_self;
    // all banks idle and no burst before entry
    issue(1'b0, 4'h1, 3'h0, 16'h0, sdram_cmd_pkg::CMD_SELF_REFRESH_ENTRY);
    `check("pwr", sdram_cmd_pkg::PWR_SELF_REFRESH, pwr_state_r)
    @(posedge mclk) term <= 1'b1;
    repeat (8) @(posedge mclk);
    `check("term", 1'b0, term_en)
    issue(1'b1, 4'h8, 3'h0, 16'h0, sdram_cmd_pkg::CMD_SELF_REFRESH_EXIT);
    `check("pwr", sdram_cmd_pkg::PWR_ACTIVE, pwr_state_r)
    repeat (8) @(posedge mclk);
    `check("term", 1'b1, term_en)
    idle(2);
    `check("cmd", sdram_cmd_pkg::CMD_NO_OPERATION, cmd_r)
  endtask : t_self

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    rst_n = 1'b0;
    term = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    ctrl_model_inst.send(1'b1, 4'h7, 3'h0, 16'h0);
    idle(2);
    t_table();
    t_burst();
    t_power();
    t_self();
    issue(1'b0, 4'h6, 3'h0, 16'h0, sdram_cmd_pkg::CMD_ILLEGAL);
    finish_test();
  end

  initial
  begin
    #200000;
    errors++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
